// *** fieldbus_status_pkg.sv ***
package fieldbus_status_pkg;

	// clock and blink timing
	localparam int unsigned CLOCK_HZ          = 50000000;
	localparam int unsigned MASTER_BLINK_HZ   = 2;
	localparam int unsigned SLOW_BLINK_HZ     = 1;
	localparam int unsigned MID_BLINK_HZ      = 2;
	localparam int unsigned FAST_BLINK_HZ     = 4;
	// half period of the fastest blink, in cycles
	localparam int unsigned FAST_HALF_CYCLES  = CLOCK_HZ / (2 * FAST_BLINK_HZ);
	localparam int unsigned PHASE_WIDTH       = 4;

	// baud detection
	localparam int unsigned RATE_COUNT        = 10;
	localparam int unsigned BIT_TIMER_WIDTH   = 13;
	localparam int unsigned BAUD_LOCK_BITS    = 8;
	localparam int unsigned BAUD_MARGIN_SHIFT = 3;

	// process data limits
	localparam int unsigned PROCESS_DATA_MAX  = 244;
	localparam int unsigned DATA_LEN_WIDTH    = 8;
	localparam int unsigned STATION_WIDTH     = 7;

	// reset values
	localparam logic [3:0]  BAUD_INDEX_RESET  = 4'h0;
	localparam logic [6:0]  STATION_RESET     = 7'h7E;

	typedef enum logic [1:0] {
		LED_OFF,
		LED_GREEN,
		LED_RED
	} led_color_type;

	typedef enum logic [1:0] {
		MODE_OFFLINE,
		MODE_STOP,
		MODE_DELETE,
		MODE_OPERATE
	} master_mode_type;

	typedef enum logic [1:0] {
		DB_NONE,
		DB_LOADING,
		DB_VALID,
		DB_INVALID
	} database_type;

	// master card state, supplied by the card controller
	typedef struct packed {
		master_mode_type       mode;
		database_type          database;
		logic [6:0]            slavesConfigured;
		logic [6:0]            slavesExchanging;
		logic                  busFault;
		logic                  holdsToken;
		logic                  fatalError;
		logic [3:0]            baudSelect;
	} master_status_type;

	// slave card state
	typedef struct packed {
		logic                  online;
		logic                  configError;
		logic                  paramMissing;
		logic                  asicInitError;
		logic [7:0]            inputLength;
		logic [7:0]            outputLength;
		logic [7:0]            configLength;
		logic [6:0]            stationConfig;
	} slave_status_type;

	// two-color led pair
	typedef struct packed {
		logic green;
		logic red;
	} led_type;

endpackage

// *** blink_divider.sv ***
`timescale 1ns/1ns
`default_nettype none
module blink_divider (
	// clock and reset
	input  wire logic                                     clock,
	input  wire logic                                     arst_n,
	// blink phases: bit0 4 Hz, bit1 2 Hz, bit2 1 Hz
	output logic [fieldbus_status_pkg::PHASE_WIDTH-1:0]  phase
);
	import fieldbus_status_pkg::*;

	logic [25:0] count;
	logic        tick;

	// one-cycle enable every half period of the fastest blink
	assign tick = (count == 26'(FAST_HALF_CYCLES - 1));

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count <= 26'h0;
		end else if (tick) begin
			count <= 26'h0;
		end else begin
			count <= count + 26'h1;
		end
	end

	// each phase bit halves the previous rate
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			phase <= 4'h0;
		end else if (tick) begin
			phase <= phase + 4'h1;
		end
	end
endmodule
`default_nettype wire

// *** fieldbus_status_indicators.sv ***
`timescale 1ns/1ns
`default_nettype none
module fieldbus_status_indicators (
	// clock and reset
	input  wire logic                                   clock,
	input  wire logic                                   arst_n,
	// master card state
	input  wire fieldbus_status_pkg::master_status_type masterStatus,
	// slave card state and bus receive line
	input  wire fieldbus_status_pkg::slave_status_type  slaveStatus,
	input  wire logic                                   busRxd,
	input  wire logic [3:0]                             address_rotary_high,
	input  wire logic [3:0]                             address_rotary_low,
	// master indicators
	output fieldbus_status_pkg::led_type                modeLed,
	output fieldbus_status_pkg::led_type                databaseLed,
	output fieldbus_status_pkg::led_type                exchangeLed,
	output fieldbus_status_pkg::led_type                tokenLed,
	output logic [3:0]                                  masterBaud,
	// slave indicators and results
	output fieldbus_status_pkg::led_type                onlineLed,
	output fieldbus_status_pkg::led_type                offlineLed,
	output fieldbus_status_pkg::led_type                errorLed,
	output logic [3:0]                                  slaveBaud,
	output logic                                        baudLocked,
	output logic [6:0]                                  stationAddress,
	output logic [7:0]                                  inputLength,
	output logic [7:0]                                  outputLength
);
	import fieldbus_status_pkg::*;

	logic [PHASE_WIDTH-1:0]     phase;
	logic                       blink1;
	logic                       blink2;
	logic                       blink4;
	logic                       allExchange;
	logic                       someExchange;
	logic                       lengthMismatch;
	logic                       rxdPrev;
	logic [BIT_TIMER_WIDTH-1:0] runTimer;
	logic [BIT_TIMER_WIDTH-1:0] shortestRun;
	logic [BAUD_LOCK_BITS-1:0]  edgeCount;
	logic [3:0]                 next_rateIndex;

	blink_divider blinkGen (
		.clock  (clock),
		.arst_n (arst_n),
		.phase  (phase)
	);

	assign blink4 = phase[0];
	assign blink2 = phase[1];
	assign blink1 = phase[2];

	// pair up a color with an on condition
	function automatic led_type paint(input led_color_type color, input logic on);
		led_type result;
		result.green = on && (color == LED_GREEN);
		result.red   = on && (color == LED_RED);
		return result;
	endfunction

	assign allExchange  = (masterStatus.slavesConfigured != 7'h00) &&
	                      (masterStatus.slavesExchanging >= masterStatus.slavesConfigured);
	assign someExchange = (masterStatus.slavesExchanging != 7'h00);

	// master lamps, fatal error overrides all with red
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			modeLed     <= '0;
			databaseLed <= '0;
			exchangeLed <= '0;
			tokenLed    <= '0;
		end else if (masterStatus.fatalError) begin
			modeLed     <= paint(LED_RED, 1'b1);
			databaseLed <= paint(LED_RED, 1'b1);
			exchangeLed <= paint(LED_RED, 1'b1);
			tokenLed    <= paint(LED_RED, 1'b1);
		end else begin
			case (masterStatus.mode)
				MODE_OPERATE: modeLed <= paint(LED_GREEN, 1'b1);
				MODE_DELETE:  modeLed <= paint(LED_GREEN, blink2);
				MODE_STOP:    modeLed <= paint(LED_RED, 1'b1);
				default:      modeLed <= '0;
			endcase
			case (masterStatus.database)
				DB_VALID:   databaseLed <= paint(LED_GREEN, 1'b1);
				DB_LOADING: databaseLed <= paint(LED_GREEN, blink2);
				DB_INVALID: databaseLed <= paint(LED_RED, 1'b1);
				default:    databaseLed <= '0;
			endcase
			if (masterStatus.busFault) begin
				exchangeLed <= paint(LED_RED, 1'b1);
			end else if (allExchange) begin
				exchangeLed <= paint(LED_GREEN, 1'b1);
			end else if (someExchange) begin
				exchangeLed <= paint(LED_GREEN, blink2);
			end else begin
				exchangeLed <= '0;
			end
			tokenLed <= paint(LED_GREEN, masterStatus.holdsToken);
		end
	end

	// master rate follows the configuration select below RATE_COUNT, otherwise keeps its value
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			masterBaud <= BAUD_INDEX_RESET;
		end else if (masterStatus.baudSelect < 4'(RATE_COUNT)) begin
			masterBaud <= masterStatus.baudSelect;
		end
	end

	assign lengthMismatch = (slaveStatus.inputLength != slaveStatus.configLength);

	// slave online and offline lamps
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			onlineLed  <= '0;
			offlineLed <= '0;
		end else begin
			onlineLed  <= paint(LED_GREEN, slaveStatus.online);
			offlineLed <= paint(LED_RED, !slaveStatus.online);
		end
	end

	// slave error lamp, chip fault takes priority
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			errorLed <= '0;
		end else if (slaveStatus.asicInitError) begin
			errorLed <= paint(LED_RED, blink4);
		end else if (slaveStatus.paramMissing && lengthMismatch) begin
			errorLed <= paint(LED_RED, blink2);
		end else if (slaveStatus.configError || lengthMismatch) begin
			errorLed <= paint(LED_RED, blink1);
		end else begin
			errorLed <= '0;
		end
	end

	// process data lengths clamped to the limit
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			inputLength  <= 8'h00;
			outputLength <= 8'h00;
		end else begin
			inputLength  <= (slaveStatus.inputLength > 8'(PROCESS_DATA_MAX)) ?
			                8'(PROCESS_DATA_MAX) : slaveStatus.inputLength;
			outputLength <= (slaveStatus.outputLength > 8'(PROCESS_DATA_MAX)) ?
			                8'(PROCESS_DATA_MAX) : slaveStatus.outputLength;
		end
	end

	// station address from configuration only, switches unused
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			stationAddress <= STATION_RESET;
		end else begin
			stationAddress <= slaveStatus.stationConfig;
		end
	end

	// map shortest seen bit time to a rate index (0 slowest)
	always_comb begin
		if (shortestRun <= 13'h0004) begin
			next_rateIndex = 4'h9;
		end else if (shortestRun <= 13'h0008) begin
			next_rateIndex = 4'h8;
		end else if (shortestRun <= 13'h0010) begin
			next_rateIndex = 4'h7;
		end else if (shortestRun <= 13'h0020) begin
			next_rateIndex = 4'h6;
		end else if (shortestRun <= 13'h0050) begin
			next_rateIndex = 4'h5;
		end else if (shortestRun <= 13'h0100) begin
			next_rateIndex = 4'h4;
		end else if (shortestRun <= 13'h0200) begin
			next_rateIndex = 4'h3;
		end else if (shortestRun <= 13'h0400) begin
			next_rateIndex = 4'h2;
		end else if (shortestRun <= 13'h0A00) begin
			next_rateIndex = 4'h1;
		end else begin
			next_rateIndex = 4'h0;
		end
	end

	// measure shortest run between line edges
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rxdPrev     <= 1'b1;
			runTimer    <= '0;
			shortestRun <= '1;
			edgeCount   <= '0;
		end else begin
			rxdPrev <= busRxd;
			if (busRxd != rxdPrev) begin
				runTimer <= '0;
				if (runTimer < shortestRun) begin
					shortestRun <= runTimer + 13'h1;
				end
				if (edgeCount != '1) begin
					edgeCount <= edgeCount + 8'h1;
				end
			end else if (runTimer != '1) begin
				runTimer <= runTimer + 13'h1;
			end else begin
				shortestRun <= '1; // long idle: search again
				edgeCount   <= '0;
			end
		end
	end

	// publish detected rate once enough edges are seen
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			slaveBaud  <= BAUD_INDEX_RESET;
			baudLocked <= 1'b0;
		end else begin
			baudLocked <= (edgeCount == '1);
			if (edgeCount == '1) begin
				slaveBaud <= next_rateIndex;
			end
		end
	end
endmodule
`default_nettype wire

// *** status_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module status_monitor (
	// clock and reset
	input wire logic                                   clock,
	input wire logic                                   arst_n,
	// card states
	input wire fieldbus_status_pkg::master_status_type masterStatus,
	input wire fieldbus_status_pkg::slave_status_type  slaveStatus,
	// lamps
	input wire fieldbus_status_pkg::led_type           modeLed,
	input wire fieldbus_status_pkg::led_type           databaseLed,
	input wire fieldbus_status_pkg::led_type           exchangeLed,
	input wire fieldbus_status_pkg::led_type           tokenLed,
	input wire fieldbus_status_pkg::led_type           onlineLed,
	input wire fieldbus_status_pkg::led_type           offlineLed,
	input wire fieldbus_status_pkg::led_type           errorLed,
	// results
	input wire logic [3:0]                             masterBaud,
	input wire logic [6:0]                             stationAddress,
	input wire logic [7:0]                             inputLength
);
	import fieldbus_status_pkg::*;
	logic live;
	logic quiet;
	// no diagnostic pending and lengths agree
	assign quiet = slaveStatus.inputLength == slaveStatus.configLength
		&& !(slaveStatus.configError || slaveStatus.paramMissing || slaveStatus.asicInitError);
	// high from the second edge after reset, so past values are real
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			live <= 1'b0;
		else
			live <= 1'b1;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	// previous cycle without and with fatal error
	sequence calm_seen;
		live && !$past(masterStatus.fatalError);
	endsequence
	sequence fatal_seen;
		live && $past(masterStatus.fatalError);
	endsequence
	a_fatal_all_red: assert property (fatal_seen |-> modeLed == 2'h1
		&& databaseLed == 2'h1 && exchangeLed == 2'h1 && tokenLed == 2'h1) else $error("fatal lamps");
	a_token_lamp: assert property (calm_seen |-> tokenLed == {$past(masterStatus.holdsToken), 1'b0})
		else $error("token lamp");
	a_fault_red: assert property (calm_seen ##0 $past(masterStatus.busFault) |-> exchangeLed == 2'h1)
		else $error("fault lamp");
	a_database_valid: assert property (calm_seen ##0 $past(masterStatus.database) == DB_VALID
		|-> databaseLed == 2'h2) else $error("database lamp");
	a_baud_select: assert property (live |-> masterBaud == ($past(masterStatus.baudSelect) < 4'hA
		? $past(masterStatus.baudSelect) : $past(masterBaud))) else $error("master baud");
	a_slave_lamps: assert property (live |-> onlineLed == {$past(slaveStatus.online), 1'b0}
		&& offlineLed == {1'b0, !$past(slaveStatus.online)}) else $error("online lamps");
	a_error_dark: assert property (live && $past(quiet) |-> errorLed == 2'h0)
		else $error("error lamp");
	a_station_config: assert property (live |-> stationAddress == $past(slaveStatus.stationConfig))
		else $error("station address");
	a_length_clamp: assert property (live |-> inputLength == ($past(slaveStatus.inputLength) > 8'hF4
		? 8'hF4 : $past(slaveStatus.inputLength))) else $error("input length");
endmodule
`default_nettype wire

// *** bus_station_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module bus_station_model (
	// clock and reset
	input wire logic        clock,
	input wire logic        arst_n,
	// traffic control
	input wire logic        enable,
	input wire logic [11:0] runCycles,
	// bus line
	output logic            busRxd
);
	logic [11:0] count;
	// toggles every runCycles while sending, idle high otherwise
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			busRxd <= 1'b1;
			count <= 12'h001;
		end else if (!enable) begin
			busRxd <= 1'b1;
			count <= 12'h001;
		end else if (count >= runCycles) begin
			busRxd <= !busRxd;
			count <= 12'h001;
		end else
			count <= count + 12'h001;
	end
endmodule
`default_nettype wire

// *** fieldbus_status_indicators_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module fieldbus_status_indicators_test;
	import fieldbus_status_pkg::*;
	localparam led_type GRN = 2'h2;
	localparam led_type RED = 2'h1;
	localparam led_type DRK = 2'h0;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	master_status_type masterStatus = '0;
	slave_status_type slaveStatus = '0;
	logic [3:0] address_rotary_high = 4'h0;
	logic [3:0] address_rotary_low = 4'h0;
	logic trafficOn = 1'b0;
	logic [11:0] runCycles = 12'h064;
	logic [3:0] expBaud = 4'h0;
	logic busRxd, baudLocked;
	led_type modeLed, databaseLed, exchangeLed, tokenLed, onlineLed, offlineLed, errorLed;
	logic [3:0] masterBaud, slaveBaud;
	logic [6:0] stationAddress;
	logic [7:0] inputLength, outputLength;
	int failures = 0;
	int check_count = 0;
	int seed = 83;
	int i;
	int n;
	// clock
	always #10 clock = ~clock;
	fieldbus_status_indicators dut (.clock, .arst_n, .masterStatus, .slaveStatus, .busRxd,
		.address_rotary_high, .address_rotary_low, .modeLed, .databaseLed, .exchangeLed,
		.tokenLed, .masterBaud, .onlineLed, .offlineLed, .errorLed, .slaveBaud, .baudLocked,
		.stationAddress, .inputLength, .outputLength);
	bus_station_model station (.clock, .arst_n, .enable(trafficOn), .runCycles, .busRxd);
	// compare helpers
	task automatic chk_led(input led_type got, input led_type exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t lamp %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t value %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// bounded wait for lock at the expected rate
	task automatic wait_lock(input logic [3:0] exp);
		for (n = 0; n < 40000 && !(baudLocked === 1'b1 && slaveBaud === exp); n++)
			@(negedge clock);
		chk_val({4'h0, slaveBaud}, {4'h0, exp});
		if (n == 40000) begin
			failures++;
			$display("[ERR] %0t no rate lock in time", $time);
			conclude();
		end
	endtask
	initial begin
		repeat (4) @(negedge clock);
		chk_led(errorLed, DRK);
		chk_val({1'b0, stationAddress}, 8'h7E);
		arst_n = 1'b1;
		// master lamps against the blink-free steady model
		for (i = 0; i < 60; i++) begin
			@(negedge clock);
			masterStatus = 25'($random(seed));
			masterStatus.fatalError = (i % 8 == 7);
			masterStatus.busFault = (i % 5 == 0);
			if (masterStatus.baudSelect < 4'hA)
				expBaud = masterStatus.baudSelect;
			@(negedge clock);
			chk_led(modeLed, masterStatus.fatalError ? RED : masterStatus.mode == MODE_OPERATE ? GRN
				: masterStatus.mode == MODE_STOP ? RED : DRK);
			chk_led(databaseLed, masterStatus.fatalError ? RED : masterStatus.database == DB_VALID
				? GRN : masterStatus.database == DB_INVALID ? RED : DRK);
			chk_led(exchangeLed, masterStatus.fatalError || masterStatus.busFault ? RED
				: masterStatus.slavesConfigured != 0 && masterStatus.slavesExchanging
				>= masterStatus.slavesConfigured ? GRN : DRK);
			chk_led(tokenLed, masterStatus.fatalError ? RED : masterStatus.holdsToken ? GRN : DRK);
			chk_val({4'h0, masterBaud}, {4'h0, expBaud});
		end
		// slave lamps, address and length clamp
		for (i = 0; i < 60; i++) begin
			@(negedge clock);
			slaveStatus = 35'({$random(seed), $random(seed)});
			{address_rotary_high, address_rotary_low} = 8'($random(seed));
			if (i[0])
				slaveStatus.configLength = slaveStatus.inputLength;
			if (i == 2)
				{slaveStatus.inputLength, slaveStatus.outputLength} = 16'hF4F5;
			@(negedge clock);
			chk_led(onlineLed, slaveStatus.online ? GRN : DRK);
			chk_led(offlineLed, slaveStatus.online ? DRK : RED);
			chk_led(errorLed, DRK);
			chk_val({1'b0, stationAddress}, {1'b0, slaveStatus.stationConfig});
			chk_val(inputLength, slaveStatus.inputLength > 8'hF4 ? 8'hF4 : slaveStatus.inputLength);
			chk_val(outputLength, slaveStatus.outputLength > 8'hF4 ? 8'hF4 : slaveStatus.outputLength);
		end
		// slow traffic, idle restart, then fast traffic
		trafficOn = 1'b1;
		wait_lock(4'h4);
		trafficOn = 1'b0;
		repeat (9000) @(negedge clock);
		runCycles = 12'h006;
		trafficOn = 1'b1;
		wait_lock(4'h8);
		conclude();
	end
endmodule
bind fieldbus_status_indicators status_monitor mon (.clock, .arst_n, .masterStatus, .slaveStatus,
	.modeLed, .databaseLed, .exchangeLed, .tokenLed, .onlineLed, .offlineLed, .errorLed,
	.masterBaud, .stationAddress, .inputLength);
`default_nettype wire
